/* File: bench/pipc_core_model.sv */
// Core model: takes vectored requests and acknowledges them after a set delay.
// Assumes one shared clock and reset with the controller.
`timescale 1ns/1ps
module pipc_core_model (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        ack_en,
    input  wire logic [3:0]  lat,
    input  wire logic        irq_high_req,
    input  wire logic        irq_low_req,
    output logic             irq_ack,
    output logic             irq_ack_high,
    output logic [20:0]      return_pc,
    output logic [7:0]       working_register,
    output logic [7:0]       status_register,
    output logic [7:0]       bank_select_register
);
    // ======
    // Core state
    logic [20:0] cnt_q;
    logic [3:0]  wait_q;
    // Changes every cycle so a capture one cycle off shows up
    assign return_pc            = cnt_q;
    assign working_register     = cnt_q[7:0];
    assign status_register      = ~cnt_q[7:0];
    assign bank_select_register = cnt_q[7:0] ^ 8'h5a;
    // ======
    // Acknowledge, promptly or after lat cycles
    always_ff @(posedge ref_clk) begin
        cnt_q        <= srst ? 21'h000000 : cnt_q + 21'h000001;
        irq_ack      <= 1'b0;
        irq_ack_high <= irq_high_req;
        if (srst || irq_ack || !ack_en || !(irq_high_req || irq_low_req)) begin
            wait_q <= 4'h0;
        end else if (wait_q == lat) begin
            irq_ack <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule // pipc_core_model

/* File: bench/test_peripheral_interrupt_priority_ctrl.sv */
// Bench: registers, reset causes, pins, priority steering, timer, port-B and context save.
// Assumes pipc_pkg compiled first and pipc_params.svh on the include path.
`timescale 1ns/1ps
`include "pipc_params.svh"
module test_peripheral_interrupt_priority_ctrl;
    logic                     ref_clk           = 1'b0;
    logic                     srst              = 1'b1;
    pipc_pkg::pipc_rst_kind_t rst_kind          = pipc_pkg::PIPC_RST_POWERON;
    logic                     cfg_soft_brownout = 1'b1;
    logic [3:0]               reg_addr          = 4'h0;
    logic [7:0]               reg_wdata         = 8'h00;
    logic                     reg_wr            = 1'b0;
    logic                     reg_rd            = 1'b0;
    logic [2:0]               ext_pin           = 3'h0;
    logic [3:0]               portb_upper       = 4'h0;
    logic [7:0]               periph_flags2     = 8'h00;
    logic [7:0]               periph_enable1    = 8'h00;
    logic [7:0]               periph_flags1     = 8'h00;
    logic                     wdt_clear         = 1'b0;
    logic                     sleep_enter       = 1'b0;
    logic                     ack_en            = 1'b0;
    logic [3:0]               lat               = 4'h0;
    logic [7:0]               reg_rdata, working_register, status_register, bank_select_register;
    logic [7:0]               fast_working, fast_status, fast_bank;
    logic [20:0]              return_pc, stack_pc;
    logic                     irq_ack, irq_ack_high, irq_high_req, irq_low_req, wake_req, stack_push;
    int                       n_errors          = 0;
    int                       check_count       = 0;

    always #50 ref_clk = ~ref_clk;

    pipc_ctrl i_dut (.ref_clk, .srst, .rst_kind, .cfg_soft_brownout, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .ext_pin, .portb_upper, .periph_enable1, .periph_flags1,
        .periph_flags2, .sleep_enter, .wdt_clear, .irq_ack, .irq_ack_high, .return_pc,
        .working_register, .status_register, .bank_select_register, .irq_high_req, .irq_low_req,
        .wake_req, .stack_push, .stack_pc, .fast_working, .fast_status, .fast_bank);
    pipc_core_model i_core (.ref_clk, .srst, .ack_en, .lat, .irq_high_req, .irq_low_req, .irq_ack,
        .irq_ack_high, .return_pc, .working_register, .status_register, .bank_select_register);

    // ======
    // Bus, compare and closing tasks
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk8(reg_rdata, exp);
    endtask
    task automatic setin(input logic [2:0] p, input logic [3:0] b);
        @(posedge ref_clk);
        ext_pin <= p;
        portb_upper <= b;
        repeat (5) @(posedge ref_clk);
    endtask
    // Timer runs from reset; stopped here so its flag stays out of the other scenarios
    task automatic do_reset(input pipc_pkg::pipc_rst_kind_t k, input logic cfg);
        @(posedge ref_clk);
        srst <= 1'b1;
        rst_kind <= k;
        cfg_soft_brownout <= cfg;
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        wr(`PIPC_A_T0CTL, 8'h40);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ======
    // Scenarios
    task automatic t_regs();
        rd(`PIPC_A_ENA2, 8'h00);
        rd(`PIPC_A_PRIO1, 8'hff);
        rd(`PIPC_A_PRIO2, 8'hdf);
        rd(`PIPC_A_RCAUSE, 8'h5c);
        wr(`PIPC_A_ENA2, 8'hff);
        rd(`PIPC_A_ENA2, 8'hdf);
        wr(`PIPC_A_PRIO2, 8'h00);
        rd(`PIPC_A_PRIO2, 8'h00);
        wr(`PIPC_A_RCAUSE, 8'hff);
        rd(`PIPC_A_RCAUSE, 8'hdf);
        wr(`PIPC_A_RCAUSE, 8'h13);
        rd(`PIPC_A_RCAUSE, 8'h1f);
        @(posedge ref_clk);
        sleep_enter <= 1'b1;
        @(posedge ref_clk);
        sleep_enter <= 1'b0;
        rd(`PIPC_A_RCAUSE, 8'h1b);
        rd(4'hf, 8'h00);
        do_reset(pipc_pkg::PIPC_RST_WATCHDOG, 1'b1);
        rd(`PIPC_A_RCAUSE, 8'h53);
        @(posedge ref_clk);
        wdt_clear <= 1'b1;
        @(posedge ref_clk);
        wdt_clear <= 1'b0;
        rd(`PIPC_A_RCAUSE, 8'h5f);
    endtask
    task automatic t_pin();
        logic       ev;
        logic [7:0] w;
        for (int i = 0; i < 2; i++) begin
            ev = i[0];
            wr(`PIPC_A_RCAUSE, {ev, 7'h00});
            wr(`PIPC_A_SIC, {1'b0, ev, 6'h35});
            setin({2'b00, ev}, portb_upper);
            wr(`PIPC_A_MIC, 8'h90);
            setin({2'b00, ~ev}, portb_upper);
            rd(`PIPC_A_MIC, 8'h90);
            setin({2'b00, ev}, portb_upper);
            rd(`PIPC_A_MIC, 8'h92);
            chk1(irq_high_req, 1'b1);
            chk1(irq_low_req, 1'b0);
            ack_en <= 1'b1;
            lat <= {2'b00, ev, ev};
            for (int k = 0; k < 20 && irq_ack !== 1'b1; k++) begin
                @(posedge ref_clk);
                #1;
            end
            w = working_register;
            @(posedge ref_clk);
            ack_en <= 1'b0;
            #1;
            chk1(stack_push, 1'b1);
            chk8(fast_working, w);
            chk8(fast_status, ~w);
            chk8(fast_bank, w ^ 8'h5a);
            chk8(stack_pc[7:0], w);
            rd(`PIPC_A_MIC, 8'h12);
            chk1(wake_req, 1'b1);
            wr(`PIPC_A_MIC, 8'h82);
            chk1(irq_high_req, 1'b0);
            wr(`PIPC_A_MIC, 8'h00);
        end
    endtask
    task automatic t_prio();
        wr(`PIPC_A_RCAUSE, 8'h80);
        wr(`PIPC_A_MIC, 8'hc0);
        wr(`PIPC_A_ENA2, 8'h01);
        wr(`PIPC_A_PRIO2, 8'h00);
        @(posedge ref_clk);
        periph_flags2 <= 8'h01;
        @(posedge ref_clk);
        #1;
        chk1(irq_low_req, 1'b1);
        chk1(irq_high_req, 1'b0);
        // Low entry drops only the low-level enable
        ack_en <= 1'b1;
        lat <= 4'h0;
        repeat (3) @(posedge ref_clk);
        ack_en <= 1'b0;
        rd(`PIPC_A_MIC, 8'h80);
        wr(`PIPC_A_MIC, 8'hc0);
        wr(`PIPC_A_PRIO2, 8'h01);
        chk1(irq_high_req, 1'b1);
        chk1(irq_low_req, 1'b0);
        wr(`PIPC_A_PRIO2, 8'h00);
        wr(`PIPC_A_RCAUSE, 8'h00);
        chk1(irq_high_req, 1'b1);
        chk1(irq_low_req, 1'b0);
        wr(`PIPC_A_ENA2, 8'h00);
        chk1(wake_req, 1'b0);
        @(posedge ref_clk);
        periph_flags2 <= 8'h00;
        wr(`PIPC_A_RCAUSE, 8'h80);
        wr(`PIPC_A_PRIO1, 8'hbf);
        rd(`PIPC_A_PRIO1, 8'hbf);
        @(posedge ref_clk);
        periph_enable1 <= 8'h40;
        periph_flags1 <= 8'h40;
        @(posedge ref_clk);
        #1;
        chk1(irq_low_req, 1'b1);
        chk1(irq_high_req, 1'b0);
        wr(`PIPC_A_RCAUSE, 8'h00);
        chk1(irq_high_req, 1'b1);
        @(posedge ref_clk);
        periph_enable1 <= 8'h00;
        periph_flags1 <= 8'h00;
    endtask
    task automatic t_misc();
        logic [7:0] hi_v [3] = '{8'h00, 8'hff, 8'hfe};
        logic [7:0] ctl;
        wr(`PIPC_A_MIC, 8'h08);
        setin(ext_pin, 4'h8);
        rd(`PIPC_A_MIC, 8'h09);
        chk1(wake_req, 1'b1);
        for (int i = 0; i < 3; i++) begin
            ctl = (i == 0) ? 8'h40 : 8'h00;
            wr(`PIPC_A_T0CTL, ctl);
            wr(`PIPC_A_T0HI, hi_v[i]);
            wr(`PIPC_A_T0LO, 8'hfe);
            wr(`PIPC_A_MIC, 8'ha0);
            wr(`PIPC_A_T0CTL, ctl | 8'h80);
            repeat (4) @(posedge ref_clk);
            rd(`PIPC_A_MIC, (i < 2) ? 8'ha4 : 8'ha0);
            chk1(irq_high_req, i < 2);
        end
        wr(`PIPC_A_T0CTL, 8'h40);
    endtask

    initial begin
        #1000000;
        n_errors++;
        stop_test();
    end
    initial begin
        do_reset(pipc_pkg::PIPC_RST_POWERON, 1'b1);
        t_regs();
        t_pin();
        t_prio();
        t_misc();
        stop_test();
    end
endmodule // test_peripheral_interrupt_priority_ctrl

/* File: src/pipc_ctrl.sv */
// Interrupt enable, priority, external-pin, timer-0 overflow, port-B change and context save logic.
// Assumes a core on ref_clk that acknowledges requests and a reset controller on the same clock.
// Operation
// - Second enable register: one enable per source, reset 0.
// - Bit 5 of enable2, priority2 and reset-cause reads 0, ignores writes.
// - Peripheral priority bits only matter when priority levels are enabled.
// - First priority register: one bit per source, 1 high, reset 1.
// - Small package: parallel slave priority bit absent, reads 0.
// - Second priority register mirrors enable2 order, reset 1.
// - Reset-cause bit 7 enables two levels; 0 means single-level legacy mode.
// - Reset-cause flags report last reset; timeout and powerdown are read-only.
// - Soft brownout enable and power-on flag reset from config and reset kind.
// - External pins edge-triggered; select 1 rising, 0 falling.
// - Valid edge sets pin flag; cleared enable blocks the interrupt.
// - Enabled external pin wakes core; branches to vector if globally enabled.
// - Pins 1, 2 use third-control priority bits; pin 0 always high.
// - Timer 0 flag set on 8-bit or 16-bit wrap.
// - Timer 0 enable main-control bit 5, priority second-control bit 2.
// - Upper port-B change sets flag bit 0; enable bit 3; priority bit 0.
// - On entry push return address, save working, status and bank registers.
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "pipc_params.svh"

module pipc_ctrl #(
    parameter bit SMALL_PACKAGE = 1'b0,
    parameter int PC_W          = 21
) (
    input  wire logic                  ref_clk,
    input  wire logic                  srst,
    input  wire pipc_pkg::pipc_rst_kind_t rst_kind,
    input  wire logic                  cfg_soft_brownout,
    input  wire logic [3:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    input  wire logic [2:0]            ext_pin,
    input  wire logic [3:0]            portb_upper,
    input  wire logic [7:0]            periph_enable1,
    input  wire logic [7:0]            periph_flags1,
    input  wire logic [7:0]            periph_flags2,
    input  wire logic                  sleep_enter,
    input  wire logic                  wdt_clear,
    input  wire logic                  irq_ack,
    input  wire logic                  irq_ack_high,
    input  wire logic [PC_W-1:0]       return_pc,
    input  wire logic [7:0]            working_register,
    input  wire logic [7:0]            status_register,
    input  wire logic [7:0]            bank_select_register,
    output logic                       irq_high_req,
    output logic                       irq_low_req,
    output logic                       wake_req,
    output logic                       stack_push,
    output logic      [PC_W-1:0]       stack_pc,
    output logic      [7:0]            fast_working,
    output logic      [7:0]            fast_status,
    output logic      [7:0]            fast_bank
);
    // ==========================================
    // Helpers
    function automatic logic hit(input logic strobe, input logic [3:0] addr, input logic [3:0] a);
        hit = strobe && (addr == a);
    endfunction

    function automatic logic [7:0] rc_after_reset(input pipc_pkg::pipc_rst_kind_t k,
                                                  input logic cfg, input logic [7:0] cur);
        logic [7:0] r;
        logic       pwr;
        r   = cur & `PIPC_MASK_RC;
        pwr = (k == pipc_pkg::PIPC_RST_POWERON);
        r[`PIPC_B_PRIORITY_LEVELS_ENABLE]   = 1'b0;
        r[`PIPC_B_SOFT_BROWNOUT_ENABLE] = cfg;
        r[`PIPC_B_RI]     = (k == pipc_pkg::PIPC_RST_INSTR) ? 1'b0 : (pwr | cur[`PIPC_B_RI]);
        r[`PIPC_B_TO]     = (k == pipc_pkg::PIPC_RST_WATCHDOG) ? 1'b0 : (pwr | cur[`PIPC_B_TO]);
        r[`PIPC_B_PD]     = pwr | cur[`PIPC_B_PD];
        r[`PIPC_B_POR]    = pwr ? 1'b0 : cur[`PIPC_B_POR];
        r[`PIPC_B_BOR]    = (pwr || k == pipc_pkg::PIPC_RST_BROWNOUT) ? 1'b0 : cur[`PIPC_B_BOR];
        rc_after_reset = r;
    endfunction

    // ==========================================
    // Pin synchronisers; the third stage only serves edge detection
    logic [2:0] ext_s1_q, ext_s2_q, ext_s3_q;
    logic [3:0] rb_s1_q, rb_s2_q, rb_s3_q;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ext_s1_q <= 3'h0;
            ext_s2_q <= 3'h0;
            ext_s3_q <= 3'h0;
            rb_s1_q  <= 4'h0;
            rb_s2_q  <= 4'h0;
            rb_s3_q  <= 4'h0;
        end else begin
            ext_s1_q <= ext_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            rb_s1_q  <= portb_upper;
            rb_s2_q  <= rb_s1_q;
            rb_s3_q  <= rb_s2_q;
        end
    end

    // ==========================================
    // Register state
    logic [7:0]  ena2_q, ena2_d, prio1_q, prio1_d, prio2_q, prio2_d, rc_q, rc_d;
    logic [7:0]  mic_q, mic_d, sic_q, sic_d, tic_q, tic_d, t0c_q, t0c_d, rdata_q, rdata_d;
    logic [15:0] t0_q, t0_d;
    logic [2:0]  edge_sel, ext_edge;
    logic        rb_change, t0_wrap, t0_write, priority_levels_enable;

    assign priority_levels_enable     = rc_q[`PIPC_B_PRIORITY_LEVELS_ENABLE];
    assign edge_sel = {sic_q[`PIPC_B_EDGE2], sic_q[`PIPC_B_EDGE1], sic_q[`PIPC_B_EDGE0]};

    // Valid edge per pin according to its select bit
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_edge
            assign ext_edge[gi] = edge_sel[gi] ? (ext_s2_q[gi] & ~ext_s3_q[gi])
                                               : (~ext_s2_q[gi] & ext_s3_q[gi]);
        end
    endgenerate

    assign rb_change = |(rb_s2_q ^ rb_s3_q);
    assign t0_write  = hit(reg_wr, reg_addr, `PIPC_A_T0LO) || hit(reg_wr, reg_addr, `PIPC_A_T0HI);
    // A software write to the count wins over the increment, so no wrap that cycle
    assign t0_wrap   = t0c_q[`PIPC_B_T0ON] && !t0_write &&
                       (t0c_q[`PIPC_B_T0M8] ? (t0_q[7:0] == `PIPC_ONES8) : (t0_q == `PIPC_ONES16));

    always_comb begin
        ena2_d  = ena2_q;
        prio1_d = prio1_q;
        prio2_d = prio2_q;
        rc_d    = rc_q;
        mic_d   = mic_q;
        sic_d   = sic_q;
        tic_d   = tic_q;
        t0c_d   = t0c_q;
        t0_d    = t0_q;
        rdata_d = `PIPC_ZERO8;
        if (hit(reg_wr, reg_addr, `PIPC_A_ENA2))
            ena2_d = reg_wdata & `PIPC_MASK_ENA2;
        if (hit(reg_wr, reg_addr, `PIPC_A_PRIO1)) begin
            prio1_d = reg_wdata;
            if (SMALL_PACKAGE)
                prio1_d[`PIPC_B_PSP] = 1'b0;
        end
        if (hit(reg_wr, reg_addr, `PIPC_A_PRIO2))
            prio2_d = reg_wdata & `PIPC_MASK_ENA2;
        if (hit(reg_wr, reg_addr, `PIPC_A_RCAUSE))
            rc_d = (rc_q & ~`PIPC_WMASK_RC) | (reg_wdata & `PIPC_WMASK_RC);
        // Sleep and watchdog clear drive the read-only flags
        if (sleep_enter) begin
            rc_d[`PIPC_B_PD] = 1'b0;
            rc_d[`PIPC_B_TO] = 1'b1;
        end
        if (wdt_clear) begin
            rc_d[`PIPC_B_PD] = 1'b1;
            rc_d[`PIPC_B_TO] = 1'b1;
        end
        if (hit(reg_wr, reg_addr, `PIPC_A_MIC))
            mic_d = reg_wdata;
        if (hit(reg_wr, reg_addr, `PIPC_A_SIC))
            sic_d = reg_wdata & `PIPC_MASK_SIC;
        if (hit(reg_wr, reg_addr, `PIPC_A_TIC))
            tic_d = reg_wdata & `PIPC_MASK_TIC;
        if (hit(reg_wr, reg_addr, `PIPC_A_T0CTL))
            t0c_d = reg_wdata & `PIPC_MASK_T0CTL;
        // Counter: a write replaces one byte, otherwise it counts while on
        if (hit(reg_wr, reg_addr, `PIPC_A_T0LO))
            t0_d = {t0_q[15:8], reg_wdata};
        else if (hit(reg_wr, reg_addr, `PIPC_A_T0HI))
            t0_d = {reg_wdata, t0_q[7:0]};
        else if (t0c_q[`PIPC_B_T0ON])
            t0_d = t0_q + `PIPC_ONE16;
        // Hardware sets come after software writes so a set never loses to a clear
        if (ext_edge[0])
            mic_d[`PIPC_B_I0IF] = 1'b1;
        if (ext_edge[1])
            tic_d[`PIPC_B_I1IF] = 1'b1;
        if (ext_edge[2])
            tic_d[`PIPC_B_I2IF] = 1'b1;
        if (t0_wrap)
            mic_d[`PIPC_B_T0IF] = 1'b1;
        if (rb_change)
            mic_d[`PIPC_B_PORTB_CHANGE_FLAG] = 1'b1;
        // Entry drops the global enable of the level being taken
        if (irq_ack) begin
            if (priority_levels_enable && !irq_ack_high)
                mic_d[`PIPC_B_PEIE] = 1'b0;
            else
                mic_d[`PIPC_B_GIE] = 1'b0;
        end
        if (reg_rd) begin
            case (reg_addr)
                `PIPC_A_ENA2:   rdata_d = ena2_q;
                `PIPC_A_PRIO1:  rdata_d = prio1_q;
                `PIPC_A_PRIO2:  rdata_d = prio2_q;
                `PIPC_A_RCAUSE: rdata_d = rc_q;
                `PIPC_A_MIC:    rdata_d = mic_q;
                `PIPC_A_SIC:    rdata_d = sic_q;
                `PIPC_A_TIC:    rdata_d = tic_q;
                `PIPC_A_T0CTL:  rdata_d = t0c_q;
                `PIPC_A_T0LO:   rdata_d = t0_q[7:0];
                `PIPC_A_T0HI:   rdata_d = t0_q[15:8];
                default:        rdata_d = `PIPC_ZERO8;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ena2_q  <= `PIPC_RST_ENA2;
            prio1_q <= SMALL_PACKAGE ? (`PIPC_RST_PRIO1 & ~8'h80) : `PIPC_RST_PRIO1;
            prio2_q <= `PIPC_RST_PRIO2;
            rc_q    <= rc_after_reset(rst_kind, cfg_soft_brownout, rc_q);
            mic_q   <= `PIPC_RST_MIC;
            sic_q   <= `PIPC_RST_SIC;
            tic_q   <= `PIPC_RST_TIC;
            t0c_q   <= `PIPC_RST_T0CTL;
            t0_q    <= `PIPC_ZERO16;
            rdata_q <= `PIPC_ZERO8;
        end else begin
            ena2_q  <= ena2_d;
            prio1_q <= prio1_d;
            prio2_q <= prio2_d;
            rc_q    <= rc_d;
            mic_q   <= mic_d;
            sic_q   <= sic_d;
            tic_q   <= tic_d;
            t0c_q   <= t0c_d;
            t0_q    <= t0_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ==========================================
    // Request steering
    logic [7:0] pend1, pend2;
    logic [4:0] core_pend, core_prio;
    logic       any_hi, any_lo, any_pend;

    assign pend1 = periph_flags1 & periph_enable1;
    assign pend2 = periph_flags2 & ena2_q;
    assign core_pend = {mic_q[`PIPC_B_PORTB_CHANGE_FLAG] & mic_q[`PIPC_B_PORTB_CHANGE_ENABLE],
                        mic_q[`PIPC_B_T0IF] & mic_q[`PIPC_B_T0IE],
                        tic_q[`PIPC_B_I2IF] & tic_q[`PIPC_B_I2IE],
                        tic_q[`PIPC_B_I1IF] & tic_q[`PIPC_B_I1IE],
                        mic_q[`PIPC_B_I0IF] & mic_q[`PIPC_B_I0IE]};
    // Pin zero has no priority bit and is tied high
    assign core_prio = {sic_q[`PIPC_B_PORTB_CHANGE_PRIORITY], sic_q[`PIPC_B_T0IP],
                        tic_q[`PIPC_B_I2IP], tic_q[`PIPC_B_I1IP], 1'b1};

    // Peripheral sources take their priority only in two-level mode
    assign any_hi = |(core_pend & core_prio) | |(pend1 & prio1_q) | |(pend2 & prio2_q);
    assign any_lo = |(core_pend & ~core_prio) | |(pend1 & ~prio1_q) | |(pend2 & ~prio2_q);

    always_comb begin
        if (priority_levels_enable) begin
            irq_high_req = mic_q[`PIPC_B_GIE] && any_hi;
            irq_low_req  = mic_q[`PIPC_B_GIE] && mic_q[`PIPC_B_PEIE] && any_lo;
        end else begin
            // Legacy single level: one vector, peripherals behind the peripheral enable
            irq_high_req = mic_q[`PIPC_B_GIE] &&
                           (|core_pend || (mic_q[`PIPC_B_PEIE] && (|pend1 || |pend2)));
            irq_low_req  = 1'b0;
        end
    end

    // Wake does not need the global enable; the vector branch follows only if it is set
    assign any_pend = |core_pend | |pend1 | |pend2;
    assign wake_req = any_pend;

    // ==========================================
    // Context save on entry
    logic            push_q, push_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic [7:0]      fw_q, fw_d, fs_q, fs_d, fb_q, fb_d;

    always_comb begin
        push_d = irq_ack;
        pc_d   = pc_q;
        fw_d   = fw_q;
        fs_d   = fs_q;
        fb_d   = fb_q;
        if (irq_ack) begin
            pc_d = return_pc;
            fw_d = working_register;
            fs_d = status_register;
            fb_d = bank_select_register;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            push_q <= 1'b0;
            pc_q   <= '0;
            fw_q   <= `PIPC_ZERO8;
            fs_q   <= `PIPC_ZERO8;
            fb_q   <= `PIPC_ZERO8;
        end else begin
            push_q <= push_d;
            pc_q   <= pc_d;
            fw_q   <= fw_d;
            fs_q   <= fs_d;
            fb_q   <= fb_d;
        end
    end

    assign stack_push   = push_q;
    assign stack_pc     = pc_q;
    assign fast_working = fw_q;
    assign fast_status  = fs_q;
    assign fast_bank    = fb_q;

    // ==========================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    property p_unimp_bit5;
        reg_rd && (reg_addr == `PIPC_A_ENA2 || reg_addr == `PIPC_A_PRIO2 || reg_addr == `PIPC_A_RCAUSE)
            |=> reg_rdata[`PIPC_B_UNIMP] == 1'b0;
    endproperty
    a_unimp_bit5: assert property (p_unimp_bit5) else $error("bit 5 read back as one");

    property p_ena2_roundtrip;
        hit(reg_wr, reg_addr, `PIPC_A_ENA2) ##1 hit(reg_rd, reg_addr, `PIPC_A_ENA2)
            |=> reg_rdata == ($past(reg_wdata, 2) & `PIPC_MASK_ENA2);
    endproperty
    a_ena2_roundtrip: assert property (p_ena2_roundtrip) else $error("enable2 readback wrong");

    property p_no_low_single;
        !priority_levels_enable |-> !irq_low_req;
    endproperty
    a_no_low_single: assert property (p_no_low_single) else $error("low request in single level");

    property p_psp_absent;
        SMALL_PACKAGE && hit(reg_rd, reg_addr, `PIPC_A_PRIO1) |=> !reg_rdata[`PIPC_B_PSP];
    endproperty
    a_psp_absent: assert property (p_psp_absent) else $error("parallel slave priority present");

    property p_pin0_flag;
        $fell(ext_s3_q[0]) && !sic_q[`PIPC_B_EDGE0] |-> mic_q[`PIPC_B_I0IF];
    endproperty
    a_pin0_flag: assert property (p_pin0_flag) else $error("falling edge missed on pin 0");

    property p_t0_wrap8;
        t0c_q[`PIPC_B_T0ON] && t0c_q[`PIPC_B_T0M8] && !t0_write && t0_q[7:0] == `PIPC_ONES8
            |=> mic_q[`PIPC_B_T0IF] && t0_q[7:0] == `PIPC_ZERO8;
    endproperty
    a_t0_wrap8: assert property (p_t0_wrap8) else $error("timer 0 wrap not flagged");

    property p_rb_change;
        rb_s2_q != rb_s3_q |=> mic_q[`PIPC_B_PORTB_CHANGE_FLAG];
    endproperty
    a_rb_change: assert property (p_rb_change) else $error("port change not flagged");

    property p_ctx_save;
        irq_ack |=> stack_push && fast_working == $past(working_register)
            && stack_pc == $past(return_pc) ##1 !stack_push || $past(irq_ack);
    endproperty
    a_ctx_save: assert property (p_ctx_save) else $error("context not saved on entry");

    property p_ro_flags;
        hit(reg_wr, reg_addr, `PIPC_A_RCAUSE) && !sleep_enter && !wdt_clear
            |=> $stable(rc_q[`PIPC_B_TO:`PIPC_B_PD]);
    endproperty
    a_ro_flags: assert property (p_ro_flags) else $error("read-only reset flag written");

    property p_pin0_high;
        priority_levels_enable && mic_q[`PIPC_B_GIE] && core_pend[0] |-> irq_high_req;
    endproperty
    a_pin0_high: assert property (p_pin0_high) else $error("pin 0 not high priority");

endmodule // pipc_ctrl

/* File: src/pipc_params.svh */
// Offsets, field positions and reset values of the interrupt priority block.
// Included by the bench and the controller; definitions only.
`ifndef PIPC_PARAMS_SVH
`define PIPC_PARAMS_SVH
// ==========================================
// Register offsets on the plain port
`define PIPC_A_ENA2   4'h0
`define PIPC_A_PRIO1  4'h1
`define PIPC_A_PRIO2  4'h2
`define PIPC_A_RCAUSE 4'h3
`define PIPC_A_MIC    4'h4
`define PIPC_A_SIC    4'h5
`define PIPC_A_TIC    4'h6
`define PIPC_A_T0CTL  4'h7
`define PIPC_A_T0LO   4'h8
`define PIPC_A_T0HI   4'h9
// ==========================================
// Implemented-bit masks and reset values
`define PIPC_MASK_ENA2  8'hdf
`define PIPC_RST_ENA2   8'h00
`define PIPC_RST_PRIO1  8'hff
`define PIPC_RST_PRIO2  8'hdf
`define PIPC_MASK_RC    8'hdf
`define PIPC_WMASK_RC   8'hd3
`define PIPC_RST_MIC    8'h00
`define PIPC_MASK_SIC   8'h75
`define PIPC_RST_SIC    8'h75
`define PIPC_MASK_TIC   8'hdb
`define PIPC_RST_TIC    8'hc0
`define PIPC_MASK_T0CTL 8'hc0
`define PIPC_RST_T0CTL  8'hc0
`define PIPC_ZERO8      8'h00
`define PIPC_ONES8      8'hff
`define PIPC_ZERO16     16'h0000
`define PIPC_ONES16     16'hffff
`define PIPC_ONE16      16'h0001
// ==========================================
// Field positions
`define PIPC_B_PSP    7
`define PIPC_B_UNIMP  5
`define PIPC_B_PRIORITY_LEVELS_ENABLE   7
`define PIPC_B_SOFT_BROWNOUT_ENABLE 6
`define PIPC_B_RI     4
`define PIPC_B_TO     3
`define PIPC_B_PD     2
`define PIPC_B_POR    1
`define PIPC_B_BOR    0
`define PIPC_B_GIE    7
`define PIPC_B_PEIE   6
`define PIPC_B_T0IE   5
`define PIPC_B_I0IE   4
`define PIPC_B_PORTB_CHANGE_ENABLE   3
`define PIPC_B_T0IF   2
`define PIPC_B_I0IF   1
`define PIPC_B_PORTB_CHANGE_FLAG   0
`define PIPC_B_EDGE0  6
`define PIPC_B_EDGE1  5
`define PIPC_B_EDGE2  4
`define PIPC_B_T0IP   2
`define PIPC_B_PORTB_CHANGE_PRIORITY   0
`define PIPC_B_I2IP   7
`define PIPC_B_I1IP   6
`define PIPC_B_I2IE   4
`define PIPC_B_I1IE   3
`define PIPC_B_I2IF   1
`define PIPC_B_I1IF   0
`define PIPC_B_T0ON   7
`define PIPC_B_T0M8   6
`endif

/* File: src/pipc_pkg.sv */
// Types shared by the interrupt priority block and its bench.
// Assumes pipc_params.svh sits beside it.
package pipc_pkg;
    // Kind of reset reported by the device reset logic
    typedef enum logic [2:0] {
        PIPC_RST_POWERON,
        PIPC_RST_BROWNOUT,
        PIPC_RST_PIN,
        PIPC_RST_WATCHDOG,
        PIPC_RST_INSTR
    } pipc_rst_kind_t;
endpackage
